// [include/scr_consts.vh]
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH
// register byte addresses
`define SCR_A_MODE 12'h248
`define SCR_A_BRG 12'h249
`define SCR_A_TB_LO 12'h24a
`define SCR_A_TB_HI 12'h24b
`define SCR_A_C0 12'h24c
`define SCR_A_C1 12'h24d
`define SCR_A_RB_LO 12'h24e
`define SCR_A_RB_HI 12'h24f
`define SCR_A_CLKSEL 12'h250
`define SCR_A_PCLK 12'h251
`define SCR_A_PROT 12'h252
// reset values
`define SCR_C0_RST 8'h08
`define SCR_MODE_RST 8'h00
`define SCR_C1_RST 8'h02
// channel_control_0 fields
`define SCR_C0_CRS 2
`define SCR_C0_SHIFT_REG_EMPTY_FLAG 3
`define SCR_C0_CRD 4
`define SCR_C0_NCH 5
`define SCR_C0_CLOCK_POLARITY_SELECT 6
`define SCR_C0_BIT_ORDER_SELECT 7
// channel_mode_reg fields
`define SCR_MR_STOP2 4
`define SCR_MR_PRY 5
`define SCR_MR_PAR_EN 6
// control register 1 fields
`define SCR_C1_TE 0
`define SCR_C1_TI 1
`define SCR_C1_RE 2
`define SCR_C1_RI 3
// clock select fields
`define SCR_CS_LOW 2
`define SCR_CS_HIGH 3
`define SCR_PCLK_HALF 0
`define SCR_PROT_UNLOCK 0
// mode_field encodings
`define SCR_MODE_OFF 3'b000
`define SCR_MODE_SYNC 3'b001
`define SCR_MODE_I2C 3'b010
`define SCR_MODE_U7 3'b100
`define SCR_MODE_U8 3'b101
`define SCR_MODE_U9 3'b110
// timing
`define SCR_OVERSAMPLE 4'hf
`define SCR_MID_SAMPLE 4'h7
`endif

// [hw/scr_rate_gen.v]
`timescale 1ns/100ps
`default_nettype none
// count source selection and bit rate divider; tick_out is a one-cycle enable
module scr_rate_gen #(
    parameter W = 8
) (
    input wire mclk_in,
    input wire reset_in,
    input wire src_en_in,
    input wire halve_in,
    input wire [1:0] cnt_src_in,
    input wire [W-1:0] brg_in,
    input wire restart_in,
    output wire tick_out
);
    reg half_q;
    reg [4:0] pre_q;
    reg [W-1:0] brg_cnt_q;
    wire base_en;
    reg cnt_en;

    // base_clk_halving_sel only applies to the undivided source choice
    assign base_en = src_en_in & (~halve_in | half_q);

    always @(posedge mclk_in) begin
        if (reset_in) begin
            half_q <= 1'b0;
            pre_q <= 5'h00;
        end else if (src_en_in) begin
            half_q <= ~half_q;
            pre_q <= pre_q + 5'h01;
        end
    end

    // source pick; code 11 yields no count at all
    always @* begin
        case (cnt_src_in)
            2'b00: cnt_en = base_en;
            2'b01: cnt_en = src_en_in & (pre_q[2:0] == 3'h7);
            2'b10: cnt_en = src_en_in & (pre_q == 5'h1f);
            default: cnt_en = 1'b0;
        endcase
    end

    // divide by brg+1; a divider write restarts the count
    always @(posedge mclk_in) begin
        if (reset_in || restart_in) begin
            brg_cnt_q <= brg_in;
        end else if (cnt_en) begin
            brg_cnt_q <= (brg_cnt_q == {W{1'b0}}) ? brg_in : brg_cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign tick_out = cnt_en & (brg_cnt_q == {W{1'b0}});
endmodule // scr_rate_gen
`default_nettype wire

// [hw/scr_channel.v]
// What this block does
// - low byte read clears framing, parity
// - overrun overwrites receive data with new char
// - arbitration flag cleared only by zero
// - error flags clear when off or disabled
// - overrun when new char ends, unread data
// - sync mode: framing, parity, sum inactive
// - framing error on missing stop bits
// - parity error on ones count mismatch
// - sum clears all-zero, sets two-or-more
// - count source 00, /8, /32, 11 unused
// - halving bit picks undivided or half
// - flow pin: 0 cts, 1 rts
// - shift empty flag shows transmit idle
// - flow disable releases the pin
// - output type 1 gives open drain
// - clock polarity swaps shift, sample edges
// - bit order: lsb or msb first
// - receive complete shows unread data
`timescale 1ns/100ps
`default_nettype none
`include "scr_consts.vh"
module scr_channel #(
    parameter HIGH_GROUP = 0
) (
    input wire mclk_in,
    input wire reset_in,
    input wire [11:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output wire [7:0] rdata_out,
    input wire alt_src_en_in,
    input wire arb_lost_in,
    input wire rxd_in,
    output wire txd_out,
    output wire txd_oe_out,
    output wire sclk_out,
    output wire sclk_oe_out,
    input wire cts_n_in,
    output wire rts_n_out,
    output wire rts_oe_out,
    output wire flow_pin_free_out
);
    // software registers
    reg [7:0] c0_q;
    reg [7:0] mode_q;
    reg [7:0] brg_q;
    reg te_q, re_q;
    reg [7:0] clksel_q;
    reg half_sel_q;
    reg unlock_q;
    reg [8:0] tb_q;
    reg ti_q;
    reg [8:0] rb_q;
    reg ri_q;
    reg oer_q, fer_q, per_q, sum_q, abt_q;
    reg [7:0] rdata_q;
    // transmit state
    reg tx_busy_q;
    reg [12:0] tx_frame_q;
    reg [3:0] tx_left_q;
    reg [3:0] tx_os_q;
    reg sclk_q;
    reg sync_out_q;
    // receive state
    reg rx_busy_q;
    reg [3:0] rx_os_q;
    reg [3:0] rx_idx_q;
    reg [12:0] rx_bits_q;
    reg [3:0] sync_idx_q;

    wire tick;
    wire [2:0] mode = mode_q[2:0];
    wire is_sync = (mode == `SCR_MODE_SYNC);
    wire is_async = (mode == `SCR_MODE_U7) | (mode == `SCR_MODE_U8) | (mode == `SCR_MODE_U9);
    wire clock_polarity_select = c0_q[`SCR_C0_CLOCK_POLARITY_SELECT];
    wire msb_first = c0_q[`SCR_C0_BIT_ORDER_SELECT];
    wire par_en = mode_q[`SCR_MR_PAR_EN];
    wire stop2 = mode_q[`SCR_MR_STOP2];
    wire flow_off = c0_q[`SCR_C0_CRD];
    wire rts_sel = c0_q[`SCR_C0_CRS];
    wire wr_c0 = wr_in & (addr_in == `SCR_A_C0);
    wire rd_rb_lo = rd_in & (addr_in == `SCR_A_RB_LO);

    // character length in bits for the current mode
    function [3:0] scr_len;
        input [2:0] m;
        begin
            case (m)
                `SCR_MODE_U7: scr_len = 4'd7;
                `SCR_MODE_U9: scr_len = 4'd9;
                default: scr_len = 4'd8;
            endcase
        end
    endfunction

    // mirror the low len bits when msb first; used on both directions
    function [8:0] scr_order;
        input [8:0] d;
        input [3:0] len;
        input msb;
        integer i;
        begin
            scr_order = 9'h000;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < len) begin
                    scr_order[i] = msb ? d[len - 1 - i] : d[i];
                end
            end
        end
    endfunction

    wire [3:0] len = scr_len(mode);
    wire [3:0] frame_cnt = 4'd1 + len + {3'b000, par_en} + (stop2 ? 4'd2 : 4'd1);

    // the pre-divider source picks between the free system rate and an alternate enable
    wire grp_sel = (HIGH_GROUP != 0) ? clksel_q[`SCR_CS_HIGH] : clksel_q[`SCR_CS_LOW];
    wire src_en = grp_sel ? alt_src_en_in : 1'b1;

    scr_rate_gen #(
        .W(8)
    ) u_rate (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .src_en_in(src_en),
        .halve_in(half_sel_q),
        .cnt_src_in(c0_q[1:0]),
        .brg_in(brg_q),
        .restart_in(wr_in & ((addr_in == `SCR_A_BRG) | (addr_in == `SCR_A_C0))),
        .tick_out(tick)
    );

    // plain configuration registers; the PCLK halving write needs the unlock bit
    always @(posedge mclk_in) begin
        if (reset_in) begin
            c0_q <= `SCR_C0_RST;
            mode_q <= `SCR_MODE_RST;
            brg_q <= 8'h00;
            te_q <= 1'b0;
            re_q <= 1'b0;
            clksel_q <= 8'h00;
            half_sel_q <= 1'b0;
            unlock_q <= 1'b0;
        end else if (wr_in) begin
            case (addr_in)
                `SCR_A_MODE: mode_q <= wdata_in;
                `SCR_A_BRG: brg_q <= wdata_in;
                `SCR_A_C0: c0_q <= wdata_in;
                `SCR_A_C1: begin
                    te_q <= wdata_in[`SCR_C1_TE];
                    re_q <= wdata_in[`SCR_C1_RE];
                end
                `SCR_A_CLKSEL: clksel_q <= wdata_in;
                `SCR_A_PROT: unlock_q <= wdata_in[`SCR_PROT_UNLOCK];
                `SCR_A_PCLK: begin
                    if (unlock_q) begin
                        half_sel_q <= wdata_in[`SCR_PCLK_HALF];
                    end
                end
                default: ;
            endcase
        end
    end

    // flow control: cts gates the start, only while enabled and selected
    wire cts_ok = flow_off | rts_sel | ~cts_n_in;
    wire tx_start = ~tx_busy_q & te_q & ~ti_q & cts_ok & (is_async | is_sync);

    // transmit buffer: the low byte write marks the buffer full, so the ninth bit goes first
    always @(posedge mclk_in) begin
        if (reset_in) begin
            tb_q <= 9'h000;
            ti_q <= 1'b1;
        end else if (wr_in && addr_in == `SCR_A_TB_HI) begin
            tb_q[8] <= wdata_in[0];
        end else if (wr_in && addr_in == `SCR_A_TB_LO) begin
            tb_q[7:0] <= wdata_in;
            ti_q <= 1'b0;
        end else if (tx_start) begin
            ti_q <= 1'b1;
        end
    end

    // outgoing frame, bit 0 goes out first
    reg [12:0] frame_d;
    reg [8:0] ord;
    integer k;
    always @* begin
        frame_d = 13'h1fff;
        ord = scr_order(tb_q, len, msb_first);
        for (k = 0; k < 9; k = k + 1) begin
            if (is_sync) begin
                if (k < 8) begin
                    frame_d[k] = ord[k];
                end
            end else if (k < len) begin
                frame_d[1 + k] = ord[k];
            end
        end
        if (is_async) begin
            frame_d[0] = 1'b0;
            if (par_en) begin
                frame_d[1 + len] = mode_q[`SCR_MR_PRY] ? ^ord : ~^ord;
            end
        end
    end

    // sync clock: idle level is high for polarity 0, low for polarity 1
    wire sclk_idle = ~clock_polarity_select;
    wire shift_edge = tick & tx_busy_q & is_sync & (sclk_q == sclk_idle);
    wire sample_edge = tick & tx_busy_q & is_sync & (sclk_q != sclk_idle);

    // transmit shifter: 16 ticks per async bit, two ticks per sync bit
    always @(posedge mclk_in) begin
        if (reset_in || mode == `SCR_MODE_OFF) begin
            tx_busy_q <= 1'b0;
            tx_frame_q <= 13'h1fff;
            tx_left_q <= 4'h0;
            tx_os_q <= 4'h0;
            sclk_q <= 1'b1;
            sync_out_q <= 1'b1;
        end else if (tx_start) begin
            tx_busy_q <= 1'b1;
            tx_frame_q <= frame_d;
            tx_left_q <= is_sync ? 4'd8 : frame_cnt;
            tx_os_q <= 4'h0;
            sclk_q <= sclk_idle;
        end else if (tx_busy_q && is_async && tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == `SCR_OVERSAMPLE) begin
                tx_frame_q <= {1'b1, tx_frame_q[12:1]};
                tx_left_q <= tx_left_q - 4'h1;
                tx_busy_q <= (tx_left_q != 4'h1);
            end
        end else if (shift_edge) begin
            sclk_q <= ~sclk_q;
            sync_out_q <= tx_frame_q[0];
            tx_frame_q <= {1'b1, tx_frame_q[12:1]};
        end else if (sample_edge) begin
            sclk_q <= ~sclk_q;
            tx_left_q <= tx_left_q - 4'h1;
            tx_busy_q <= (tx_left_q != 4'h1);
        end else if (!tx_busy_q) begin
            sclk_q <= sclk_idle;
            sync_out_q <= 1'b1;
        end
    end

    // async receiver: start bit found low, each bit sampled mid-cell
    wire rx_hunt = ~rx_busy_q & re_q & is_async & ~rxd_in;
    wire rx_mid = rx_busy_q & tick & (rx_os_q == `SCR_MID_SAMPLE);
    wire rx_false = rx_mid & (rx_idx_q == 4'h0) & rxd_in;
    wire async_done = rx_mid & ~rx_false & (rx_idx_q == frame_cnt - 4'h1);
    always @(posedge mclk_in) begin
        if (reset_in || !re_q || !is_async) begin
            rx_busy_q <= 1'b0;
            rx_os_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_bits_q <= 13'h0000;
        end else if (rx_hunt) begin
            rx_busy_q <= 1'b1;
            rx_os_q <= 4'h0;
            rx_idx_q <= 4'h0;
        end else if (rx_busy_q && tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_mid) begin
                rx_bits_q[rx_idx_q] <= rxd_in;
                rx_idx_q <= rx_idx_q + 4'h1;
                rx_busy_q <= ~rx_false & ~async_done;
            end
        end
    end

    // sync receiver rides on the transmit clock's sample edges
    wire sync_done = sample_edge & re_q & (sync_idx_q == 4'd7);
    always @(posedge mclk_in) begin
        if (reset_in || tx_start) begin
            sync_idx_q <= 4'h0;
        end else if (sample_edge) begin
            sync_idx_q <= sync_idx_q + 4'h1;
        end
    end

    // assemble the finished character including the bit just sampled
    reg [12:0] full;
    reg [8:0] rx_raw;
    reg [8:0] rx_word;
    reg rx_fer, rx_per;
    integer j;
    always @*
    begin
        full = rx_bits_q;
        if (is_sync) begin
            full = {1'b0, tx_frame_q[12:1]};
            full[12:5] = 8'h00;
            full[sync_idx_q] = rxd_in;
        end else begin
            full[rx_idx_q] = rxd_in;
        end
        rx_raw = 9'h000;
        for (j = 0; j < 9; j = j + 1) begin
            if (j < len) begin
                rx_raw[j] = is_sync ? full[j] : full[1 + j];
            end
        end
        rx_word = scr_order(rx_raw, len, msb_first);
        rx_fer = ~full[frame_cnt - 4'h1] | (stop2 & ~full[frame_cnt - 4'h2]);
        rx_per = par_en & ((^rx_raw ^ full[1 + len]) == mode_q[`SCR_MR_PRY]);
    end
    wire rx_done = async_done | sync_done;

    // receive buffer and error flags
    wire clr_all = (mode == `SCR_MODE_OFF) | ~re_q;
    reg oer_d, fer_d, per_d, sum_d;
    always @* begin
        oer_d = oer_q;
        fer_d = fer_q;
        per_d = per_q;
        if (rd_rb_lo) begin
            fer_d = 1'b0;
            per_d = 1'b0;
        end
        if (rx_done) begin
            oer_d = oer_q | ri_q;
            fer_d = is_async & rx_fer;
            per_d = is_async & rx_per;
        end
        if (clr_all) begin
            oer_d = 1'b0;
            fer_d = 1'b0;
            per_d = 1'b0;
        end
        sum_d = sum_q;
        if ((oer_d & fer_d) | (oer_d & per_d) | (fer_d & per_d)) begin
            sum_d = 1'b1;
        end else if (!(oer_d | fer_d | per_d)) begin
            sum_d = 1'b0;
        end
    end

    always @(posedge mclk_in) begin
        if (reset_in) begin
            rb_q <= 9'h000;
            ri_q <= 1'b0;
            oer_q <= 1'b0;
            fer_q <= 1'b0;
            per_q <= 1'b0;
            sum_q <= 1'b0;
        end else begin
            oer_q <= oer_d;
            fer_q <= fer_d;
            per_q <= per_d;
            sum_q <= sum_d;
            if (rx_done) begin
                rb_q <= rx_word;
                ri_q <= 1'b1;
            end else if (rd_rb_lo || clr_all) begin
                ri_q <= 1'b0;
            end
        end
    end

    // arbitration flag: hardware sets, software can only clear; the set wins
    always @(posedge mclk_in) begin
        if (reset_in) begin
            abt_q <= 1'b0;
        end else if (arb_lost_in) begin
            abt_q <= 1'b1;
        end else if (wr_in && addr_in == `SCR_A_RB_HI && !wdata_in[3]) begin
            abt_q <= 1'b0;
        end
    end

    // read mux; data stands only in the cycle after the strobe
    wire err_vis = is_async;
    always @(posedge mclk_in) begin
        if (reset_in || !rd_in) begin
            rdata_q <= 8'h00;
        end else begin
            case (addr_in)
                `SCR_A_MODE: rdata_q <= mode_q;
                `SCR_A_BRG: rdata_q <= brg_q;
                `SCR_A_C0: rdata_q <= {c0_q[7:4], ~tx_busy_q, c0_q[2:0]};
                `SCR_A_C1: rdata_q <= {4'h0, ri_q, re_q, ti_q, te_q};
                `SCR_A_RB_LO: rdata_q <= rb_q[7:0];
                `SCR_A_RB_HI: rdata_q <= {sum_q & err_vis, per_q & err_vis, fer_q & err_vis,
                    oer_q, abt_q, 2'b00, rb_q[8]};
                `SCR_A_CLKSEL: rdata_q <= clksel_q;
                `SCR_A_PCLK: rdata_q <= {7'h00, half_sel_q};
                `SCR_A_PROT: rdata_q <= {7'h00, unlock_q};
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign rdata_out = rdata_q;

    // line pins; open drain only ever pulls low
    wire txd_val = is_sync ? sync_out_q : tx_frame_q[0] | ~tx_busy_q;
    wire on = (mode != `SCR_MODE_OFF);
    wire output_type_select = c0_q[`SCR_C0_NCH];
    assign txd_out = txd_val;
    assign txd_oe_out = on & (~output_type_select | ~txd_val);
    assign sclk_out = sclk_q;
    assign sclk_oe_out = is_sync & (~output_type_select | ~sclk_q);

    // rts low means ready: receiver on and the buffer drained
    assign rts_n_out = ~(re_q & ~ri_q);
    assign rts_oe_out = on & ~flow_off & rts_sel;
    assign flow_pin_free_out = flow_off;
endmodule // scr_channel
`default_nettype wire

// [bench/scr_channel_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scr_consts.vh"
// pin and read data checks against shadow copies of the bus-written fields
module scr_channel_monitor (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic alt_src_en_in,
    input wire logic arb_lost_in,
    input wire logic rxd_in,
    input wire logic txd_out,
    input wire logic txd_oe_out,
    input wire logic sclk_out,
    input wire logic sclk_oe_out,
    input wire logic cts_n_in,
    input wire logic rts_n_out,
    input wire logic rts_oe_out,
    input wire logic flow_pin_free_out
);
    logic [7:0] c0_q;
    logic [2:0] md_q;
    logic re_q;
    logic abt_q;
    wire rb_rd = rd_in && addr_in == `SCR_A_RB_HI;
    wire off_now = md_q == `SCR_MODE_OFF || !re_q;
    // shadows; a set pulse wins over the clearing write, as in the flag
    always @(posedge mclk_in) begin
        if (reset_in) begin
            c0_q <= `SCR_C0_RST;
            md_q <= 3'b000;
            re_q <= 1'b0;
            abt_q <= 1'b0;
        end else begin
            if (wr_in && addr_in == `SCR_A_C0)
                c0_q <= wdata_in;
            if (wr_in && addr_in == `SCR_A_MODE)
                md_q <= wdata_in[2:0];
            if (wr_in && addr_in == `SCR_A_C1)
                re_q <= wdata_in[`SCR_C1_RE];
            if (arb_lost_in)
                abt_q <= 1'b1;
            else if (wr_in && addr_in == `SCR_A_RB_HI && !wdata_in[3])
                abt_q <= 1'b0;
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside its slot");
    chk_c0_readback: assert property ($past(rd_in && addr_in == `SCR_A_C0) |->
        {rdata_out[7:4], rdata_out[2:0]} == {c0_q[7:4], c0_q[2:0]})
        else $error("control 0 read back differs from written value");
    chk_flow_free: assert property (flow_pin_free_out == c0_q[4])
        else $error("flow pin release does not follow disable bit");
    chk_rts_drive: assert property (rts_oe_out == (c0_q[2] && !c0_q[4] && |md_q))
        else $error("rts drive enable wrong for flow settings");
    chk_rts_ready: assert property (!re_q && !$past(re_q) && rts_oe_out |-> rts_n_out)
        else $error("rts shows ready while reception is off");
    chk_open_drain: assert property (c0_q[5] && $past(c0_q[5]) && txd_out |-> !txd_oe_out)
        else $error("data line driven high in open drain setting");
    chk_arb_flag: assert property ($past(rb_rd) |-> rdata_out[3] == $past(abt_q))
        else $error("arbitration flag read value wrong");
    chk_flags_off: assert property ($past(rb_rd) && $past(off_now) && $past(off_now, 2)
        |-> rdata_out[7:4] == 4'h0)
        else $error("error flags set while off or reception disabled");
    chk_sync_quiet: assert property ($past(rb_rd) && $past(md_q == `SCR_MODE_SYNC)
        |-> rdata_out[7:5] == 3'h0)
        else $error("async error flags visible in sync mode");
    chk_reset_outs: assert property ($fell(reset_in) |-> txd_out && !txd_oe_out
        && rts_n_out && !rts_oe_out && sclk_out && !sclk_oe_out)
        else $error("pins not at idle levels after reset");
    cover property ($past(rb_rd) && rdata_out[6]);
    cover property ($past(rb_rd) && rdata_out[4]);
    cover property ($past(rb_rd) && rdata_out[7]);
endmodule // scr_channel_monitor
bind scr_channel scr_channel_monitor mon (.mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .alt_src_en_in, .arb_lost_in, .rxd_in, .txd_out, .txd_oe_out,
    .sclk_out, .sclk_oe_out, .cts_n_in, .rts_n_out, .rts_oe_out, .flow_pin_free_out);
`default_nettype wire

// [bench/scr_line_peer.sv]
`timescale 1ns/100ps
`default_nettype none
// remote station: even parity, one stop bit, lsb first
module scr_line_peer #(
    parameter int BIT = 32
) (
    input wire logic mclk_in,
    input wire logic line_in,
    output logic rxd_out,
    output logic [7:0] got_out,
    output logic got_vld_out
);
    // bad_stop holds the line low through the stop slot
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] fr;
        fr = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_out <= fr[i];
            repeat (BIT) @(posedge mclk_in);
        end
        if (bad_stop)
            rxd_out <= 1'b1;
    endtask
    // catcher samples mid-bit; parity and stop slots are skipped
    initial begin
        rxd_out = 1'b1;
        got_out = 8'h00;
        got_vld_out = 1'b0;
        forever begin
            @(negedge line_in);
            repeat (BIT / 2) @(posedge mclk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge mclk_in);
                got_out[i] <= line_in;
            end
            repeat (BIT * 2) @(posedge mclk_in);
            got_vld_out <= 1'b1;
            @(posedge mclk_in);
            got_vld_out <= 1'b0;
        end
    end
endmodule // scr_line_peer
`default_nettype wire

// [bench/scr_channel_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scr_consts.vh"
module scr_channel_bench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] addr_in = 12'h000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic alt_src_en_in = 1'b0;
    logic arb_lost_in = 1'b0;
    logic cts_n_in = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] exp_q[$], msk_q[$], tx_q[$];
    logic [11:0] a_q[$];
    int errors = 0;
    int total_checks = 0;
    wire rxd_in, got_vld, txd_out, txd_oe_out, rts_n_out, rts_oe_out, flow_pin_free_out;
    wire [7:0] rdata_out;
    wire [7:0] got;
    wire txd_line = txd_oe_out ? txd_out : 1'b1; // pull-up when released
    always #2.5 mclk_in = ~mclk_in;
    scr_channel DUT (.mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .alt_src_en_in, .arb_lost_in, .rxd_in, .txd_out, .txd_oe_out, .sclk_out(),
        .sclk_oe_out(), .cts_n_in, .rts_n_out, .rts_oe_out, .flow_pin_free_out);
    scr_line_peer #(.BIT(32)) peer (.mclk_in, .line_in(txd_line), .rxd_out(rxd_in),
        .got_out(got), .got_vld_out(got_vld));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    // the note is queued as the strobe goes out; the watcher settles it
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] k);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        a_q.push_back(a);
        exp_q.push_back(e);
        msk_q.push_back(k);
        @(posedge mclk_in);
        rd_in <= 1'b0;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge mclk_in) begin
        alt_src_en_in <= 1'($urandom);
        if (rd_d) begin
            m = msk_q.pop_front();
            chk($sformatf("reg_%h", a_q.pop_front()), exp_q.pop_front() & m, rdata_out & m);
        end
        if (got_vld)
            chk("line_byte", tx_q.pop_front(), got);
        rd_d <= rd_in;
    end
    initial begin
        wait_n(20000);
        errors++;
        $display("MISMATCH run_time expected finish seen timeout");
        end_sim;
    end
    initial begin
        d = 8'($urandom(32'h1c20));
        wait_n(3);
        reset_in <= 1'b0;
        wr(`SCR_A_CLKSEL, 8'h00);
        rd(`SCR_A_C0, `SCR_C0_RST, 8'hff);
        rd(`SCR_A_C1, `SCR_C1_RST, 8'hff);
        wr(12'h3f0, 8'h5a);
        rd(12'h3f0, 8'h00, 8'hff);
        wr(`SCR_A_PROT, 8'h01);
        wr(`SCR_A_PCLK, 8'h00);
        wr(`SCR_A_PROT, 8'h00);
        wr(`SCR_A_PCLK, 8'h01);
        rd(`SCR_A_PCLK, 8'h00, 8'h01);
        wr(`SCR_A_PROT, 8'h01);
        wr(`SCR_A_PCLK, 8'h01);
        rd(`SCR_A_PCLK, 8'h01, 8'h01);
        wr(`SCR_A_PCLK, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(`SCR_A_C0, {6'h01, 2'(2 - i)}); // ends on the undivided source
            rd(`SCR_A_C0, {6'h03, 2'(2 - i)}, 8'hff);
        end
        $display("test registers done");
        // 8-bit even parity, divider 1: 32 clocks a bit
        wr(`SCR_A_MODE, 8'h65);
        wr(`SCR_A_BRG, 8'h01);
        wr(`SCR_A_C1, 8'h05);
        #1;
        chk("rts_oe", 8'h01, 8'(rts_oe_out));
        chk("rts_n", 8'h00, 8'(rts_n_out));
        d = 8'($urandom);
        peer.send(d, 1'b0, 1'b0);
        wait_n(40);
        #1;
        chk("rts_full", 8'h01, 8'(rts_n_out));
        rd(`SCR_A_C1, 8'h0c, 8'h0c);
        rd(`SCR_A_RB_HI, 8'h00, 8'hf8);
        rd(`SCR_A_RB_LO, d, 8'hff);
        rd(`SCR_A_C1, 8'h04, 8'h0c);
        d = 8'($urandom);
        peer.send(d, 1'b1, 1'b0);
        wait_n(40);
        rd(`SCR_A_RB_HI, 8'h40, 8'hf8);
        rd(`SCR_A_RB_LO, d, 8'hff);
        rd(`SCR_A_RB_HI, 8'h00, 8'hf8);
        peer.send(8'($urandom), 1'b0, 1'b0);
        peer.send(8'($urandom), 1'b0, 1'b0);
        wait_n(40);
        rd(`SCR_A_RB_HI, 8'h10, 8'hf8);
        rd(`SCR_A_RB_LO, 8'h00, 8'h00);
        wr(`SCR_A_C1, 8'h01);
        rd(`SCR_A_RB_HI, 8'h00, 8'hf0);
        wr(`SCR_A_C1, 8'h05);
        d = 8'($urandom);
        peer.send(d, 1'b1, 1'b1);
        wait_n(40);
        rd(`SCR_A_RB_HI, 8'he0, 8'hf8);
        rd(`SCR_A_RB_LO, d, 8'hff);
        rd(`SCR_A_RB_HI, 8'h00, 8'hf8);
        // a missing stop leaves the line low; switching off drops the false start
        wr(`SCR_A_MODE, 8'h00);
        rd(`SCR_A_RB_HI, 8'h00, 8'hf0);
        wr(`SCR_A_MODE, 8'h01);
        rd(`SCR_A_RB_HI, 8'h00, 8'he0);
        wr(`SCR_A_MODE, 8'h00);
        wr(`SCR_A_MODE, 8'h65);
        @(posedge mclk_in);
        arb_lost_in <= 1'b1;
        @(posedge mclk_in);
        arb_lost_in <= 1'b0;
        rd(`SCR_A_RB_HI, 8'h08, 8'h08);
        wr(`SCR_A_RB_HI, 8'h08);
        rd(`SCR_A_RB_HI, 8'h08, 8'h08);
        wr(`SCR_A_RB_HI, 8'h00);
        rd(`SCR_A_RB_HI, 8'h00, 8'h08);
        $display("test receive done");
        wr(`SCR_A_C0, 8'h00);
        cts_n_in <= 1'b1;
        d = 8'($urandom);
        tx_q.push_back(d);
        wr(`SCR_A_TB_HI, 8'h00);
        wr(`SCR_A_TB_LO, d);
        wait_n(60);
        rd(`SCR_A_C0, 8'h08, 8'hff);
        cts_n_in <= 1'b0;
        wait_n(5);
        rd(`SCR_A_C0, 8'h00, 8'hff);
        wait_n(420);
        wr(`SCR_A_C0, 8'ha4);
        d = 8'($urandom);
        tx_q.push_back({d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]});
        wr(`SCR_A_TB_LO, d);
        wait_n(420);
        rd(`SCR_A_C0, 8'hac, 8'hff);
        wr(`SCR_A_C0, 8'h14);
        #1;
        chk("pin_free", 8'h01, 8'(flow_pin_free_out));
        chk("rts_oe_off", 8'h00, 8'(rts_oe_out));
        $display("test transmit done");
        end_sim;
    end
endmodule // scr_channel_bench
`default_nettype wire
